// ---- ppm_defines.svh ----
`ifndef PPM_DEFINES_SVH
`define PPM_DEFINES_SVH

// byte offsets of the registers in configuration space
`define PPM_OFF_PWR_CSR 8'ha4
`define PPM_OFF_BRIDGE_EXT 8'ha6
`define PPM_OFF_DATA_READOUT 8'ha7
// dword index holding all three registers
`define PPM_DWORD_INDEX 6'h29

// field positions in the control/status word
`define PPM_BIT_WAKE_FLAG 15
`define PPM_BIT_WAKE_EN 8
`define PPM_PS_MSB 1
`define PPM_PS_LSB 0

// reset and fixed values
`define PPM_PWR_CSR_RESET 16'h0000
`define PPM_BRIDGE_EXT_VALUE 8'hc0
`define PPM_DATA_READOUT_VALUE 8'h00
`define PPM_BPCC_ENABLE_VALUE 1'b1
`define PPM_D3_ACTION_VALUE 1'b1

`endif

// ---- ppm_pkg.sv ----
`default_nettype none
package ppm_pkg;
	typedef enum logic [1:0] {
		PPM_D0 = 2'h0,
		PPM_D1 = 2'h1,
		PPM_D2 = 2'h2,
		PPM_D3HOT = 2'h3
	} ppm_pstate_t;
endpackage
`default_nettype wire

// ---- ppm_wake_if.sv ----
`default_nettype none
interface ppm_wake_if;
	logic flag_clear;
	logic enable_wr;
	logic enable_val;
	logic bus_reset;
	logic flag;
	logic enable;
	modport ctl (output flag_clear, output enable_wr, output enable_val, output bus_reset,
		input flag, input enable);
	modport wake (input flag_clear, input enable_wr, input enable_val, input bus_reset,
		output flag, output enable);
endinterface
`default_nettype wire

// ---- ppm_wake_unit.sv ----
`include "ppm_defines.svh"
`default_nettype none
module ppm_wake_unit
	import ppm_pkg::*;
(
	// clock and global reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// wake source
	input wire logic wake_event_req,
	// control side
	ppm_wake_if.wake w,
	// wake pin drive
	output logic pme_oe
);
	logic flag_r;
	logic flag_nxt;
	logic enable_r;
	logic enable_nxt;
	logic pme_oe_r;

	assign w.flag = flag_r;
	assign w.enable = enable_r;
	assign pme_oe = pme_oe_r;

	always_comb begin
		enable_nxt = enable_r;
		if (w.enable_wr) begin
			enable_nxt = w.enable_val;
		end
	end

	always_comb begin
		flag_nxt = flag_r;
		if (w.bus_reset && !enable_r) begin
			flag_nxt = 1'b0;
		end else if (wake_event_req) begin
			flag_nxt = 1'b1;
		end else if (w.flag_clear) begin
			flag_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			enable_r <= 1'b0;
		end else begin
			enable_r <= enable_nxt;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			flag_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pme_oe_r <= 1'b0;
		end else begin
			pme_oe_r <= flag_nxt & enable_nxt;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	property p_wake_set;
		(wake_event_req && !(w.bus_reset && !enable_r)) |=> flag_r;
	endproperty
	a_wake_set: assert property (p_wake_set) else $error("wake flag not set by event");

	property p_wake_clear;
		(w.flag_clear && !wake_event_req) |=> !flag_r && !pme_oe_r;
	endproperty
	a_wake_clear: assert property (p_wake_clear) else $error("wake flag or pin not cleared");

	property p_pin_gate;
		pme_oe_r |-> (enable_r && flag_r);
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("pin driven without enable");

	property p_pin_follow;
		(flag_r && enable_r) |-> pme_oe_r;
	endproperty
	a_pin_follow: assert property (p_pin_follow) else $error("pin not driven");

	property p_enable_survives;
		(w.bus_reset && !w.enable_wr) |=> (enable_r == $past(enable_r));
	endproperty
	a_enable_survives: assert property (p_enable_survives) else $error("enable lost on bus reset");

	property p_bus_reset_flag;
		(w.bus_reset && !enable_r) |=> !flag_r;
	endproperty
	a_bus_reset_flag: assert property (p_bus_reset_flag) else $error("flag kept on bus reset");

	property p_context_kept;
		(w.bus_reset && enable_r && flag_r && !w.flag_clear) |=> flag_r;
	endproperty
	a_context_kept: assert property (p_context_kept) else $error("context flag lost");
endmodule
`default_nettype wire

// ---- ppm_csr_top.sv ----
`include "ppm_defines.svh"
`default_nettype none
module ppm_csr_top
	import ppm_pkg::*;
#(
	parameter logic BPCC_ENABLE = `PPM_BPCC_ENABLE_VALUE,
	parameter logic D3_ACTION = `PPM_D3_ACTION_VALUE
) (
	// clock and resets
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic pci_bus_reset_input_n,
	// configuration access
	input wire logic cfg_rd,
	input wire logic cfg_wr,
	input wire logic [5:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rvalid,
	// wake event and pin
	input wire logic wake_event_req,
	output logic wake_pin_o,
	output logic wake_pin_oe,
	// secondary bus policy
	output logic sec_clk_stop,
	output logic sec_power_off,
	output logic internal_reset
);
	ppm_wake_if wif ();

	ppm_pstate_t pstate_r;
	ppm_pstate_t pstate_nxt;
	logic hit;
	logic wr_hit;
	logic rd_hit;
	logic [15:0] csr_word;
	logic [7:0] bridge_ext;
	logic [31:0] read_word;
	logic [31:0] rdata_r;
	logic rvalid_r;
	logic int_reset_r;
	logic clk_stop_r;
	logic power_off_r;
	logic pin_o_r;
	logic bus_reset;

	assign bus_reset = !pci_bus_reset_input_n;
	assign hit = (cfg_addr == `PPM_DWORD_INDEX);
	assign wr_hit = cfg_wr && hit;
	assign rd_hit = cfg_rd && hit;

	// wake control strobes from the register write and the bus reset
	// write one clears
	assign wif.flag_clear = wr_hit && cfg_be[1] && cfg_wdata[`PPM_BIT_WAKE_FLAG];
	assign wif.enable_wr = wr_hit && cfg_be[1];
	assign wif.enable_val = cfg_wdata[`PPM_BIT_WAKE_EN];
	assign wif.bus_reset = bus_reset;

	ppm_wake_unit u_wake (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.wake_event_req(wake_event_req),
		.w(wif.wake),
		.pme_oe(wake_pin_oe)
	);

	always_comb begin
		pstate_nxt = pstate_r;
		if (wr_hit && cfg_be[0]) begin
			pstate_nxt = ppm_pstate_t'(cfg_wdata[`PPM_PS_MSB:`PPM_PS_LSB]);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pstate_r <= PPM_D0;
		end else if (bus_reset) begin
			pstate_r <= PPM_D0;
		end else begin
			pstate_r <= pstate_nxt;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			int_reset_r <= 1'b0;
		end else begin
			int_reset_r <= !bus_reset && (pstate_r == PPM_D3HOT) && (pstate_nxt == PPM_D0);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			clk_stop_r <= 1'b0;
			power_off_r <= 1'b0;
		end else begin
			clk_stop_r <= BPCC_ENABLE && D3_ACTION && (pstate_r == PPM_D3HOT);
			power_off_r <= BPCC_ENABLE && !D3_ACTION && (pstate_r == PPM_D3HOT);
		end
	end

	// open-drain wake pin only ever pulls low
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pin_o_r <= 1'b0;
		end else begin
			pin_o_r <= 1'b0;
		end
	end

	always_comb begin
		csr_word = `PPM_PWR_CSR_RESET;
		csr_word[`PPM_BIT_WAKE_FLAG] = wif.flag;
		csr_word[`PPM_BIT_WAKE_EN] = wif.enable;
		csr_word[`PPM_PS_MSB:`PPM_PS_LSB] = pstate_r;
	end

	always_comb begin
		bridge_ext = `PPM_BRIDGE_EXT_VALUE;
		bridge_ext[7] = BPCC_ENABLE;
		bridge_ext[6] = D3_ACTION;
	end

	always_comb begin
		read_word = 32'h0000_0000;
		if (hit) begin
			read_word = {`PPM_DATA_READOUT_VALUE, bridge_ext, csr_word};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rdata_r <= 32'h0000_0000;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= cfg_rd;
			if (cfg_rd) begin
				rdata_r <= read_word;
			end
		end
	end

	assign cfg_rdata = rdata_r;
	assign cfg_rvalid = rvalid_r;
	assign internal_reset = int_reset_r;
	assign sec_clk_stop = clk_stop_r;
	assign sec_power_off = power_off_r;
	assign wake_pin_o = pin_o_r;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	sequence s_read_hit;
		cfg_rd && hit ##1 rvalid_r;
	endsequence

	sequence s_leave_d3;
		(pstate_r == PPM_D3HOT) && wr_hit && cfg_be[0] && !bus_reset
			&& (cfg_wdata[`PPM_PS_MSB:`PPM_PS_LSB] == 2'h0);
	endsequence

	property p_zero_fields;
		s_read_hit |-> (rdata_r[14:9] == 6'h00);
	endproperty
	a_zero_fields: assert property (p_zero_fields) else $error("scale/select not zero");

	property p_reserved;
		s_read_hit |-> (rdata_r[7:2] == 6'h00) && (rdata_r[21:16] == 6'h00);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

	property p_bridge_bits;
		s_read_hit |-> (rdata_r[23:22] == 2'h3);
	endproperty
	a_bridge_bits: assert property (p_bridge_bits) else $error("bridge bits not one");

	property p_data_zero;
		s_read_hit |-> (rdata_r[31:24] == 8'h00);
	endproperty
	a_data_zero: assert property (p_data_zero) else $error("data readout not zero");

	property p_state_write;
		(wr_hit && cfg_be[0] && !bus_reset) |=> (pstate_r == $past(cfg_wdata[1:0]));
	endproperty
	a_state_write: assert property (p_state_write) else $error("power state not written");

	property p_state_read;
		s_read_hit |-> (rdata_r[1:0] == $past(pstate_r)) && (rdata_r[15] == $past(wif.flag));
	endproperty
	a_state_read: assert property (p_state_read) else $error("csr readback wrong");

	property p_leave_d3;
		s_leave_d3 |=> int_reset_r ##1 !int_reset_r;
	endproperty
	a_leave_d3: assert property (p_leave_d3) else $error("no internal reset pulse");

	property p_survive;
		int_reset_r |-> (pstate_r == PPM_D0) && (wif.enable == $past(wif.enable_wr ?
			wif.enable_val : wif.enable));
	endproperty
	a_survive: assert property (p_survive) else $error("csr disturbed by internal reset");

	property p_clk_stop;
		(pstate_r == PPM_D3HOT) |=> (clk_stop_r == (BPCC_ENABLE && D3_ACTION));
	endproperty
	a_clk_stop: assert property (p_clk_stop) else $error("secondary clock not stopped");

	property p_no_policy;
		(clk_stop_r || power_off_r) |-> BPCC_ENABLE && ($past(pstate_r) == PPM_D3HOT);
	endproperty
	a_no_policy: assert property (p_no_policy) else $error("policy without enable");

	property p_ro_write;
		(wr_hit && !cfg_be[0] && !cfg_be[1] && !bus_reset && !wake_event_req)
			|=> $stable(pstate_r) && $stable(wif.flag) && $stable(wif.enable);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write changed state");
endmodule
`default_nettype wire

// ---- ppm_host_model.sv ----
`default_nettype none
module ppm_host_model (
	// clock
	input wire logic clk_sys,
	// configuration requests
	output logic cfg_rd,
	output logic cfg_wr,
	output logic [5:0] cfg_addr,
	output logic [3:0] cfg_be,
	output logic [31:0] cfg_wdata,
	// read answer
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_rvalid
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		cfg_rd = 1'b0;
		cfg_wr = 1'b0;
		cfg_addr = 6'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0000_0000;
	end

	// one-cycle write strobe; data is inverted afterwards so stale data cannot pass
	task automatic wr(input logic [5:0] a, input logic [3:0] b, input logic [31:0] v);
		@(posedge clk_sys);
		cfg_wr <= 1'b1;
		cfg_addr <= a;
		cfg_be <= b;
		cfg_wdata <= v;
		@(posedge clk_sys);
		cfg_wr <= 1'b0;
		cfg_be <= ~b;
		cfg_wdata <= ~v;
	endtask

	// answer must arrive exactly one cycle after the taking edge
	task automatic rd(input logic [5:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		cfg_rd <= 1'b1;
		cfg_addr <= a;
		@(posedge clk_sys);
		cfg_rd <= 1'b0;
		@(posedge clk_sys);
		v = (cfg_rvalid === 1'b1) ? cfg_rdata : 32'hxxxx_xxxx;
	endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [5:0] IDX = 6'h29;
	logic clk_sys, reset_n, bus_rst_n, wake_req;
	logic cfg_rd, cfg_wr, cfg_rvalid, pin_o, pin_oe, clk_stop, pwr_off, int_rst;
	logic [5:0] cfg_addr;
	logic [3:0] cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata, d;
	int bad_count, comparisons;

	ppm_csr_top i_ppm_csr_top (.clk_sys(clk_sys), .reset_n(reset_n), .pci_bus_reset_input_n(bus_rst_n),
		.cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .wake_event_req(wake_req), .wake_pin_o(pin_o),
		.wake_pin_oe(pin_oe), .sec_clk_stop(clk_stop), .sec_power_off(pwr_off), .internal_reset(int_rst));
	ppm_host_model i_ppm_host_model (.clk_sys(clk_sys), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.cfg_rvalid(cfg_rvalid));

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			$display("BAD time=%0t seen=%h expected=%h", $time, seen, exp);
			bad_count++;
		end
	endtask

	task automatic complete_run();
		$display("mismatches=%0d comparisons=%0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// one-cycle pulse of the bus reset or of the wake source
	task automatic pulse(input bit bus);
		@(posedge clk_sys);
		bus_rst_n <= !bus;
		wake_req <= !bus;
		@(posedge clk_sys);
		bus_rst_n <= 1'b1;
		wake_req <= 1'b0;
		#1;
	endtask

	initial begin
		repeat (1000) @(posedge clk_sys);
		bad_count++;
		complete_run();
	end

	initial begin
		reset_n = 1'b0;
		bus_rst_n = 1'b1;
		wake_req = 1'b0;
		bad_count = 0;
		comparisons = 0;
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		i_ppm_host_model.rd(IDX, d);
		check(d, 32'h00c0_0000);
		i_ppm_host_model.rd(6'h28, d);
		check(d, 32'h0000_0000);
		i_ppm_host_model.wr(IDX, 4'hf, 32'hffff_ffff);
		i_ppm_host_model.rd(IDX, d);
		check(d, 32'h00c0_0103);
		check({30'h0, clk_stop, pwr_off}, 32'h0000_0002);
		i_ppm_host_model.wr(IDX, 4'h1, 32'h0000_0000);
		#1;
		check({31'h0, int_rst}, 32'h0000_0001);
		@(posedge clk_sys);
		#1;
		check({31'h0, int_rst}, 32'h0000_0000);
		for (int s = 0; s < 4; s++) begin
			i_ppm_host_model.wr(IDX, 4'h1, 32'(s));
			i_ppm_host_model.rd(IDX, d);
			check(d, 32'h00c0_0100 | 32'(s));
		end
		pulse(1'b0);
		check({30'h0, pin_o, pin_oe}, 32'h0000_0001);
		i_ppm_host_model.wr(IDX, 4'h2, 32'h0000_0100);
		i_ppm_host_model.wr(IDX, 4'hc, 32'hffff_ffff);
		i_ppm_host_model.rd(IDX, d);
		check(d, 32'h00c0_8103);
		pulse(1'b1);
		i_ppm_host_model.rd(IDX, d);
		check(d, 32'h00c0_8100);
		i_ppm_host_model.wr(IDX, 4'h2, 32'h0000_8100);
		i_ppm_host_model.rd(IDX, d);
		check(d, 32'h00c0_0100);
		check({31'h0, pin_oe}, 32'h0000_0000);
		fork
			i_ppm_host_model.wr(IDX, 4'h2, 32'h0000_8100);
			pulse(1'b0);
		join
		i_ppm_host_model.rd(IDX, d);
		check(d, 32'h00c0_8100);
		i_ppm_host_model.wr(IDX, 4'h2, 32'h0000_0000);
		pulse(1'b0);
		check({31'h0, pin_oe}, 32'h0000_0000);
		i_ppm_host_model.rd(IDX, d);
		check(d, 32'h00c0_8000);
		pulse(1'b1);
		i_ppm_host_model.rd(IDX, d);
		check(d, 32'h00c0_0000);
		i_ppm_host_model.wr(IDX, 4'h2, 32'h0000_0100);
		@(posedge clk_sys);
		reset_n <= 1'b0;
		@(posedge clk_sys);
		reset_n <= 1'b1;
		i_ppm_host_model.rd(IDX, d);
		check(d, 32'h00c0_0000);
		complete_run();
	end
endmodule
`default_nettype wire
